// ---- include/trig_match_pkg.sv ----
// constants, types and helper functions for the sequential trigger matcher
package trig_match_pkg;

  // trigger bus width limits and stage count
  localparam int MIN_WIDTH  = 1;
  localparam int MAX_WIDTH  = 40;
  localparam int NUM_STAGES = 3;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INFO_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  localparam logic [7:0] MASK_BASE  = 8'h10;  // stage s, mask k, half h: base+s*32+k*8+h*4
  localparam logic [7:0] MASK_END   = 8'h70;

  // control register fields
  localparam int CTRL_ARM_BIT    = 0;
  localparam int CTRL_CANCEL_BIT = 1;
  localparam int CTRL_NSTAGE_LSB = 2;
  localparam int CTRL_AND_LSB    = 4;

  // status register fields
  localparam int STAT_SEQ_LSB   = 0;
  localparam int STAT_STAGE_LSB = 2;
  localparam int STAT_CAPT_BIT  = 4;

  // info register fields
  localparam int INFO_NSTAGE_LSB = 8;

  // mask kinds within one stage
  localparam logic [1:0] MASK_PAT  = 2'h0;
  localparam logic [1:0] MASK_EDGE = 2'h1;
  localparam logic [1:0] MASK_DC   = 2'h2;

  // reset values
  localparam logic [1:0] NSTAGE_RST = 2'h1;
  localparam logic [2:0] AND_RST    = 3'h7;

  // record counter saturates here
  localparam logic [7:0] RECORD_LIMIT = 8'h80;

  // sequencer states
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_HUNT = 2'b01,
    SEQ_DONE = 2'b10
  } seq_t;

  // one channel's condition: edge or level against the pattern bit
  function automatic logic chan_ok(input logic cur, input logic prev,
                                   input logic pat, input logic edg);
    if (edg)
      chan_ok = pat ? (cur & ~prev) : (~cur & prev);
    else
      chan_ok = (cur == pat);
  endfunction

  // index of the final active stage; zero stages behaves as one
  function automatic logic [1:0] last_stage(input logic [1:0] nstage);
    case (nstage)
      2'h2:    last_stage = 2'h1;
      2'h3:    last_stage = 2'h2;
      default: last_stage = 2'h0;
    endcase
  endfunction

endpackage

// ---- logic/stage_matcher.sv ----
// one trigger stage: per-channel conditions combined by and/or
`timescale 1ns/1ps
module stage_matcher
#(
  parameter int TW = 40
)
(
  input  wire logic [TW-1:0] sample,   // current trigger sample
  input  wire logic [TW-1:0] prev,     // sample of the previous clock
  input  wire logic [TW-1:0] pat,      // level / edge direction
  input  wire logic [TW-1:0] edg,      // edge select
  input  wire logic [TW-1:0] dc,       // don't care
  input  wire logic          use_and,  // 1 = and, 0 = or
  output      logic [TW-1:0] ok,       // raw per-channel condition
  output      logic          hit       // stage match
);
  import trig_match_pkg::*;

  logic all_dc;  // every channel masked

  // per-channel evaluation
  always_comb
  begin
    for (int i = 0; i < TW; i++)
    begin
      ok[i] = chan_ok(sample[i], prev[i], pat[i], edg[i]);
    end
  end

  // combine the channels that are not masked
  always_comb
  begin
    all_dc = &dc;
    if (all_dc)
      hit = 1'b1;
    else if (use_and)
      hit = &(ok | dc);
    else
      hit = |(ok & ~dc);
  end

endmodule // stage_matcher

// ---- logic/trig_seq_top.sv ----
// sequential trigger matcher with an ahb-lite register slave
`timescale 1ns/1ps
module trig_seq_top
#(
  parameter int TW = trig_match_pkg::MAX_WIDTH
)
(
  input  wire logic          clk,             // user clock
  input  wire logic          reset_n,         // async reset, active low
  input  wire logic          hsel,            // ahb slave select
  input  wire logic [31:0]   haddr,           // ahb address
  input  wire logic [1:0]    htrans,          // ahb transfer type
  input  wire logic          hwrite,          // ahb write
  input  wire logic [2:0]    hsize,           // ahb size, word only
  input  wire logic [31:0]   hwdata,          // ahb write data
  input  wire logic          hready,          // ahb bus ready
  output      logic [31:0]   hrdata,          // ahb read data
  output      logic          hreadyout,       // ahb slave ready
  output      logic          hresp,           // ahb response, always okay
  input  wire logic [TW-1:0] trig_in,         // trigger bus from the user design
  output      logic          trig_fire,       // one-cycle pulse at the trigger
  output      logic          capture_active   // post-trigger sampling window
);
  import trig_match_pkg::*;

  // whole module state
  typedef struct packed {
    seq_t                   seq;      // sequencer state
    logic [1:0]             stage;    // stage being evaluated
    logic [1:0]             nstage;   // number of active stages
    logic [2:0]             use_and;  // per-stage combining
    logic [2:0][2:0][TW-1:0] mask;    // [stage][kind] masks
    logic [TW-1:0]          prev;     // previous trigger sample
    logic                   fire;     // trigger pulse
    logic                   capt;     // post-trigger window
    logic [7:0]             records;  // triggers since last clear
    logic                   ph_wr;    // write data phase pending
    logic [7:0]             ph_addr;  // address of that phase
    logic [31:0]            rdata;    // read data register
    logic                   ready;    // hreadyout register
  } state_t;

  // reset value: all stages don't care, and-combining, one stage
  localparam state_t ST_RESET = '{
    seq:     SEQ_IDLE,
    stage:   2'h0,
    nstage:  NSTAGE_RST,
    use_and: AND_RST,
    mask:    {3{{TW{1'b1}}, {TW{1'b0}}, {TW{1'b0}}}},
    prev:    '0,
    fire:    1'b0,
    capt:    1'b0,
    records: 8'h00,
    ph_wr:   1'b0,
    ph_addr: 8'h00,
    rdata:   32'h0000_0000,
    ready:   1'b1
  };

  state_t                st;          // registered state
  state_t                next_st;     // next state
  logic [2:0][TW-1:0]    stage_ok;    // raw channel conditions per stage
  logic [2:0]            stage_hit;   // stage match flags
  logic                  seq_fire;    // final stage matched this clock
  logic                  wr_arm;      // arm written
  logic                  wr_cancel;   // cancel written
  logic                  addr_phase;  // address phase accepted
  logic [7:0]            rel;         // offset into mask block
  logic [63:0]           wide;        // mask widened to two words

  // one matcher per stage, each with its own combining bit
  for (genvar s = 0; s < NUM_STAGES; s++)
  begin : g_stage
    stage_matcher #(
      .TW(TW)
    ) u_match (
      .sample  (trig_in),
      .prev    (st.prev),
      .pat     (st.mask[s][MASK_PAT]),
      .edg     (st.mask[s][MASK_EDGE]),
      .dc      (st.mask[s][MASK_DC]),
      .use_and (st.use_and[s]),
      .ok      (stage_ok[s]),
      .hit     (stage_hit[s])
    );
  end

  // final stage match while hunting
  assign seq_fire = (st.seq == SEQ_HUNT) && stage_hit[st.stage] &&
                    (st.stage == last_stage(st.nstage));
  assign addr_phase = hsel && hready && htrans[1];

  // next-state logic
  always_comb
  begin
    next_st       = st;
    wr_arm        = 1'b0;
    wr_cancel     = 1'b0;
    rel           = 8'h00;
    wide          = 64'h0;
    next_st.fire  = 1'b0;
    next_st.ready = 1'b1;
    next_st.prev  = trig_in;

    // write data phase
    if (st.ph_wr)
    begin
      if (st.ph_addr == CTRL_OFS)
      begin
        next_st.nstage  = hwdata[CTRL_NSTAGE_LSB +: 2];
        next_st.use_and = hwdata[CTRL_AND_LSB +: 3];
        wr_arm          = hwdata[CTRL_ARM_BIT];
        wr_cancel       = hwdata[CTRL_CANCEL_BIT];
      end
      else if (st.ph_addr == COUNT_OFS)
      begin
        next_st.records = 8'h00;                      // any write clears, unless a trigger below the limit lands in the same cycle
      end
      else if (st.ph_addr >= MASK_BASE && st.ph_addr < MASK_END)
      begin
        rel = st.ph_addr - MASK_BASE;
        if (rel[4:3] != 2'h3)
        begin
          // one 32-bit half of a mask, bit n is channel n
          wide = 64'(st.mask[rel[6:5]][rel[4:3]]);
          if (rel[2])
            wide[63:32] = hwdata;
          else
            wide[31:0] = hwdata;
          next_st.mask[rel[6:5]][rel[4:3]] = TW'(wide);
        end
      end
    end

    // stage sequencer
    case (st.seq)
      SEQ_HUNT:
      begin
        if (seq_fire)
        begin
          // single record per arm: stop hunting
          next_st.seq  = SEQ_DONE;
          next_st.fire = 1'b1;
          next_st.capt = 1'b1;
          if (st.records != RECORD_LIMIT)
            next_st.records = st.records + 8'h01;
        end
        else if (stage_hit[st.stage])
        begin
          // later stages are only looked at from the next clock
          next_st.stage = st.stage + 2'h1;
        end
      end
      SEQ_IDLE:
      begin
        next_st.stage = st.stage;                     // waiting for arm
      end
      SEQ_DONE:
      begin
        next_st.stage = st.stage;                     // window open until re-arm or cancel
      end
      default:
      begin
        next_st.seq = SEQ_IDLE;
      end
    endcase

    // cancel beats arm; a trigger in the same cycle still counts
    if (wr_cancel)
    begin
      next_st.seq  = SEQ_IDLE;
      next_st.capt = 1'b0;
    end
    else if (wr_arm)
    begin
      next_st.seq   = SEQ_HUNT;
      next_st.stage = 2'h0;
      next_st.capt  = seq_fire;
    end

    // address phase: latch write, or prepare read data
    next_st.ph_wr = addr_phase && hwrite;
    if (addr_phase)
    begin
      next_st.ph_addr = haddr[7:0];
    end
    if (addr_phase && !hwrite)
    begin
      next_st.rdata = 32'h0000_0000;                  // unmapped reads zero
      if (haddr[7:0] == CTRL_OFS)
      begin
        next_st.rdata[CTRL_NSTAGE_LSB +: 2] = next_st.nstage;
        next_st.rdata[CTRL_AND_LSB +: 3]    = next_st.use_and;
      end
      else if (haddr[7:0] == STATUS_OFS)
      begin
        next_st.rdata[STAT_SEQ_LSB +: 2]   = next_st.seq;
        next_st.rdata[STAT_STAGE_LSB +: 2] = next_st.stage;
        next_st.rdata[STAT_CAPT_BIT]       = next_st.capt;
      end
      else if (haddr[7:0] == INFO_OFS)
      begin
        next_st.rdata[7:0]                 = 8'(TW);  // host checks its width setting
        next_st.rdata[INFO_NSTAGE_LSB +: 2] = 2'(NUM_STAGES);
      end
      else if (haddr[7:0] == COUNT_OFS)
      begin
        next_st.rdata[7:0] = next_st.records;
      end
      else if (haddr[7:0] >= MASK_BASE && haddr[7:0] < MASK_END)
      begin
        rel = haddr[7:0] - MASK_BASE;
        if (rel[4:3] != 2'h3)
        begin
          wide = 64'(next_st.mask[rel[6:5]][rel[4:3]]);
          next_st.rdata = rel[2] ? wide[63:32] : wide[31:0];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // outputs straight from the state register, hresp tied to okay
  assign hrdata         = st.rdata;
  assign hreadyout      = st.ready;
  assign hresp          = 1'b0;
  assign trig_fire      = st.fire;
  assign capture_active = st.capt;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_FIRE_LAST: assert property (
    trig_fire |-> $past(st.seq) == SEQ_HUNT && $past(st.stage) == last_stage($past(st.nstage)))
    else $error("trigger fired outside the final stage");

  AST_THREE_LATER: assert property (
    (trig_fire && $past(st.nstage) == 2'h3) |-> $past(st.stage, 1) == 2'h2 &&
      $past(st.seq, 2) == SEQ_HUNT)
    else $error("three-stage trigger without the earlier stages");

  AST_ONE_STEP: assert property (
    (st.seq == SEQ_HUNT && !wr_arm && !wr_cancel) |=> st.stage <= $past(st.stage) + 2'h1)
    else $error("sequencer skipped a stage");

  AST_ARM_RESTART: assert property (
    (wr_arm && !wr_cancel) |=> st.seq == SEQ_HUNT && st.stage == 2'h0)
    else $error("arm did not restart at stage one");

  AST_SINGLE: assert property (
    (seq_fire && !wr_arm) |=> st.seq != SEQ_HUNT ##1 !trig_fire)
    else $error("more than one record per arm");

  AST_PREV: assert property (
    ##1 st.prev == $past(trig_in))
    else $error("previous sample not kept");

  AST_RISE: assert property (
    (st.mask[0][MASK_EDGE][0] && st.mask[0][MASK_PAT][0]) |->
      stage_ok[0][0] == (trig_in[0] && !$past(trig_in[0])))
    else $error("rising edge condition wrong");

  AST_FALL: assert property (
    (st.mask[0][MASK_EDGE][0] && !st.mask[0][MASK_PAT][0]) |->
      stage_ok[0][0] == (!trig_in[0] && $past(trig_in[0])))
    else $error("falling edge condition wrong");

  AST_LEVEL: assert property (
    !st.mask[1][MASK_EDGE][0] |-> stage_ok[1][0] == (trig_in[0] == st.mask[1][MASK_PAT][0]))
    else $error("level condition wrong");

  AST_ALL_DC: assert property (
    (st.seq == SEQ_HUNT && &st.mask[st.stage][MASK_DC] && !wr_arm && !wr_cancel) |=>
      (trig_fire || st.stage == $past(st.stage) + 2'h1))
    else $error("all don't-care stage did not match");

  AST_AND: assert property (
    (st.use_and[2] && stage_hit[2] && !(&st.mask[2][MASK_DC])) |->
      ((stage_ok[2] | st.mask[2][MASK_DC]) == {TW{1'b1}}))
    else $error("and stage matched with a failing channel");

  AST_OR: assert property (
    (!st.use_and[1] && !(&st.mask[1][MASK_DC])) |->
      stage_hit[1] == ((stage_ok[1] & ~st.mask[1][MASK_DC]) != '0))
    else $error("or stage match wrong");

endmodule // trig_seq_top

// ---- sim/tb_trig_seq_top.sv ----
// self-checking bench for the sequential trigger matcher
`timescale 1ns/1ps
module tb_trig_seq_top;
  import trig_match_pkg::*;
  localparam int TW = 40;            // full width, uses the high mask words
  logic          clk;
  logic          reset_n;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  logic [TW-1:0] src_val;           // value handed to the partner
  logic [TW-1:0] trig_in;           // trigger bus seen by the design
  logic          trig_fire;
  logic          capture_active;
  logic          rand_on;           // random bus traffic on
  logic [TW-1:0] m_pat [3];         // expected stage masks
  logic [TW-1:0] m_edg [3];
  logic [TW-1:0] m_dc [3];
  logic [2:0]    m_and;             // per-stage and/or
  logic [1:0]    m_nst;             // stage count
  logic [TW-1:0] m_prev;            // previous bus sample
  logic [1:0]    m_stage;
  logic          m_hunt;
  logic          m_fire;
  logic          m_cap;
  int            m_cnt;             // expected record count
  int            miscompares;
  int            num_checks;
  logic [31:0]   rd;                // last read data

  // free-running clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  trig_seq_top #(.TW(TW)) dut_u
  (
    .clk            (clk),
    .reset_n        (reset_n),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (3'b010),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hrdata         (hrdata),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .trig_in        (trig_in),
    .trig_fire      (trig_fire),
    .capture_active (capture_active)
  );

  trig_source #(.TW(TW)) src_u
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .value    (src_val),
    .trig_bus (trig_in)
  );

  // compares and counts
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // expected stage match from the masks
  function automatic logic ref_hit(input logic [TW-1:0] cur, input int s);
    logic [TW-1:0] ok;
    logic [TW-1:0] care;
    care = ~m_dc[s];
    for (int i = 0; i < TW; i++)
      ok[i] = m_edg[s][i] ? (m_pat[s][i] ? (cur[i] & ~m_prev[i]) : (~cur[i] & m_prev[i]))
                          : (cur[i] == m_pat[s][i]);
    if (care == '0)
      return 1'b1;
    return m_and[s] ? ((ok & care) == care) : ((ok & care) != '0);
  endfunction

  // reference sequencer, compared with the fire pulse every edge
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      m_prev <= '0;
      m_hunt <= 1'b0;
      m_fire <= 1'b0;
      m_cap  <= 1'b0;
      m_cnt  <= 0;
    end
    else
    begin
      check("trig_fire", {31'h0, trig_fire}, {31'h0, m_fire});
      m_fire <= 1'b0;
      if (m_hunt && ref_hit(trig_in, m_stage))
      begin
        // final active stage fires, others step on
        if (m_stage == ((m_nst == 2'h0) ? 2'h0 : m_nst - 2'h1))
        begin
          m_fire <= 1'b1;
          m_cap  <= 1'b1;
          m_hunt <= 1'b0;
          m_cnt  <= (m_cnt < 128) ? m_cnt + 1 : m_cnt;
        end
        else
          m_stage <= m_stage + 2'h1;
      end
      m_prev <= trig_in;
    end
  end

  // random bus traffic from the partner
  always @(posedge clk)
    if (rand_on)
      src_val <= TW'({$urandom, $urandom});

  // one single ahb transfer, waits on ready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1 && n++ < 100);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);  // a run-out wait counts as a mismatch
    htrans <= 2'b00;
    hwdata <= d;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1 && n++ < 100);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // writes the six mask words of one stage
  task automatic load_stage(input int s);
    logic [63:0] w [3];
    w = '{64'(m_pat[s]), 64'(m_edg[s]), 64'(m_dc[s])};
    for (int k = 0; k < 6; k++)
      ahb(1'b1, MASK_BASE + 8'(s * 32 + k * 4), w[k / 2][(k % 2) * 32 +: 32]);
  endtask

  // control write; arm restarts the reference at stage one
  task automatic ctrl(input logic arm, input logic cancel);
    ahb(1'b1, CTRL_OFS, {25'h0, m_and, m_nst, cancel, arm});
    m_hunt  <= arm & ~cancel;
    m_stage <= 2'h0;
    m_cap   <= 1'b0;
  endtask

  // waits for the reference to leave the hunt
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    while (m_hunt && n++ < 600)
      @(posedge clk);
    check("hunt_done", {31'h0, m_hunt}, 32'h0);
    repeat (2) @(posedge clk);
    check("capture", {31'h0, capture_active}, {31'h0, m_cap});
  endtask

  // hang guard
  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end

  localparam logic [7:0]  RST_OFS [7] = '{CTRL_OFS, STATUS_OFS, INFO_OFS, COUNT_OFS,
                                          8'h10, 8'h20, 8'h28};
  localparam logic [31:0] RST_VAL [7] = '{32'h74, 32'h0, 32'h328, 32'h0,
                                          32'h0, 32'hffffffff, 32'h0};

  // main sequence
  initial
  begin
    int c;
    reset_n = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    src_val = '0;
    rand_on = 1'b0;
    m_and   = 3'h7;
    m_nst   = 2'h1;
    m_pat   = '{default: '0};
    m_edg   = '{default: '0};
    m_dc    = '{default: '1};
    miscompares = 0;
    num_checks  = 0;
    void'($urandom(32'h7ebf));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // reset values, a refused write and an unmapped slot
    ahb(1'b1, STATUS_OFS, 32'hffffffff);
    foreach (RST_OFS[i])
    begin
      ahb(1'b0, RST_OFS[i], 32'h0);
      check("reset_reg", rd, RST_VAL[i]);
    end
    // immediate capture: three stages all don't care
    m_nst = 2'h3;
    ctrl(1'b1, 1'b0);
    wait_idle();
    ahb(1'b0, STATUS_OFS, 32'h0);
    check("status", rd & 32'h13, 32'h12);
    // cancel while a level stage cannot match
    m_nst    = 2'h1;
    m_dc[0]  = ~TW'(1);
    m_pat[0] = TW'(1);
    load_stage(0);
    ctrl(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    ctrl(1'b0, 1'b1);
    src_val <= '1;
    repeat (5) @(posedge clk);
    ahb(1'b0, STATUS_OFS, 32'h0);
    check("status", rd & 32'h13, 32'h0);
    // random sequences; trial zero uses channels 0 and top
    rand_on <= 1'b1;
    for (int t = 0; t < 24; t++)
    begin
      m_nst = 2'($urandom_range(1, 3));
      m_and = 3'($urandom);
      for (int s = 0; s < 3; s++)
      begin
        m_dc[s]  = '1;
        m_edg[s] = '0;
        m_pat[s] = '0;
        for (int k = 0; k < 2; k++)
        begin
          c = (t == 0) ? (k * (TW - 1)) : $urandom_range(0, TW - 1);
          m_dc[s][c]  = 1'b0;
          m_edg[s][c] = 1'($urandom);
          m_pat[s][c] = 1'($urandom);
        end
        load_stage(s);
      end
      ctrl(1'b1, 1'b0);
      wait_idle();
    end
    ahb(1'b0, COUNT_OFS, 32'h0);
    check("count", rd, 32'(m_cnt));
    // repeated arming saturates the record count
    ahb(1'b1, COUNT_OFS, 32'h0);
    m_dc = '{default: '1};
    for (int s = 0; s < 3; s++)
      load_stage(s);
    for (int t = 0; t < 130; t++)
    begin
      m_nst = 2'($urandom_range(0, 3));
      ctrl(1'b1, 1'b0);
      wait_idle();
    end
    ahb(1'b0, COUNT_OFS, 32'h0);
    check("count", rd, 32'h80);
    finish_test();
  end
endmodule // tb_trig_seq_top

// ---- sim/trig_source.sv ----
// partner model: user design logic that drives the trigger bus
`timescale 1ns/1ps
module trig_source
#(
  parameter int TW = 40
)
(
  input  wire logic          clk,      // user clock
  input  wire logic          reset_n,  // async reset, active low
  input  wire logic [TW-1:0] value,    // next bus value picked by the bench
  output      logic [TW-1:0] trig_bus  // registered trigger bus
);
  // launches the bus just after each edge, like a flop in the user design
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      trig_bus <= '0;
    else
      trig_bus <= value;
  end
endmodule // trig_source
